// file: rtl/drb_pkg.sv
// Purpose: shared constants for the dma ring buffer handshake block
// Assumes: avalon-mm byte addressing, 32-bit data, register index times four is the byte address
// Notes:   64-bit registers put their upper word at the index plus REG_HI_OFS
package drb_pkg;
	localparam int unsigned CNT_W       = 64;
	localparam int unsigned ADDR_W      = 12;
	localparam int unsigned IDX_W       = 10;
	// register indexes
	localparam logic [9:0]  REG_USER_LENGTH  = 10'h0c8;
	localparam logic [9:0]  REG_USER_POS  = 10'h0c9;
	localparam logic [9:0]  REG_CARD_REL  = 10'h0ca;
	localparam logic [9:0]  REG_CTRL      = 10'h0d0;
	localparam logic [9:0]  REG_STATUS    = 10'h0d1;
	localparam logic [9:0]  REG_BUF_LEN   = 10'h0d2;
	localparam logic [9:0]  REG_NOTIFY    = 10'h0d3;
	localparam logic [9:0]  REG_FILL      = 10'h0d4;
	localparam logic [9:0]  REG_HI_OFS    = 10'h100;
	// control register fields
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned CTRL_DIR_BIT   = 1;
	localparam int unsigned CTRL_STOP_BIT  = 2;
	// status register fields
	localparam int unsigned STAT_RUN_BIT   = 0;
	localparam int unsigned STAT_OVR_BIT   = 1;
	localparam int unsigned STAT_UNR_BIT   = 2;
	localparam int unsigned STAT_BLK_BIT   = 3;
	localparam int unsigned STAT_DIR_BIT   = 4;
	// reset values
	localparam logic [63:0] BUF_LEN_RST   = 64'h0000_0000_0001_0000;
	localparam logic [31:0] NOTIFY_RST    = 32'h0000_1000;
	// fill level scaling
	localparam int unsigned FILL_LEVELS   = 16;
	localparam int unsigned PERMILLE_FULL = 1000;
	typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_HALT} drb_phase_t;
endpackage

// file: rtl/drb_fill_permille.sv
// Purpose: converts the sixteen-level fifo fill indication to per mille
// Assumes: level runs 0 to 16, 16 meaning the on-board memory is full
// Notes:   result is registered, one cycle behind the level
`timescale 1ns/1ps
`default_nettype none
module drb_fill_permille
	import drb_pkg::*;
(
	input  wire logic       ref_clk_i,   // system clock
	input  wire logic       reset_i,     // sync reset, active high
	input  wire logic [4:0] level_i,     // fill level in sixteenths
	output logic      [9:0] permille_o   // fill level in per mille
);
	typedef struct packed {
		logic [9:0] permille;
	} drb_fill_state_t;

	drb_fill_state_t s_q;
	drb_fill_state_t s_d;
	logic [4:0]      lvl;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		// saturate above full so a bad level cannot overflow the result
		lvl = (level_i > 5'(FILL_LEVELS)) ? 5'(FILL_LEVELS) : level_i;
		s_d = s_q;
		s_d.permille = 10'((15'(lvl) * 15'(PERMILLE_FULL)) / 15'(FILL_LEVELS));
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign permille_o = s_q.permille;
endmodule // drb_fill_permille
`default_nettype wire

// file: rtl/drb_ring_ctrl.sv
// Purpose: ring-buffer handshake counters of a scatter-gather dma engine
// Assumes: data movement is done outside; it reports moved bytes on dma_bytes_i with a dma_done_i pulse
// Notes:   avalon-mm slave with one wait cycle per access
// Operation
// - user available length is readable
// - start byte index of the user available region is readable
// - host writes a byte count that the card may use again
// - separate user and card byte counters are kept
// - host to card: user length is free space, release marks filled bytes
// - card to host: user length is new data, release returns free space
// - fifo fill read in per mille from a sixteen-level indication
// - after start user length is zero, card length is whole buffer
// - user length grows only in whole notify-size blocks
// - event raised once a whole notify block is available
// - polled user length is also rounded to notify size
// - dma keeps moving data until the card space is used up
// - fifo keeps absorbing data while the host buffer is full
// - fifo overrun or underrun stops transfer and sets a status flag
// - after overrun remaining fifo data still drains to the host
// - first announced user position is zero
// - each next user region starts where released bytes ended
`timescale 1ns/1ps
`default_nettype none
module drb_ring_ctrl
	import drb_pkg::*;
(
	input  wire logic              ref_clk_i,          // 25 MHz clock
	input  wire logic              reset_i,            // sync reset, active high
	input  wire logic [ADDR_W-1:0] avs_address_i,      // byte address
	input  wire logic              avs_read_i,         // read request
	input  wire logic              avs_write_i,        // write request
	input  wire logic [31:0]       avs_writedata_i,    // write data
	input  wire logic [3:0]        avs_byteenable_i,   // byte lanes
	output logic      [31:0]       avs_readdata_o,     // read data
	output logic                   avs_waitrequest_o,  // stall
	input  wire logic              dma_done_i,         // chunk moved, one cycle
	input  wire logic [31:0]       dma_bytes_i,        // bytes in that chunk
	input  wire logic [4:0]        fifo_level_i,       // fifo fill in sixteenths
	input  wire logic              fifo_empty_i,       // on-board fifo empty
	input  wire logic              fifo_overrun_i,     // fifo overrun seen
	input  wire logic              fifo_underrun_i,    // fifo underrun seen
	output logic                   dma_move_o,         // dma may move data
	output logic      [CNT_W-1:0]  dma_pos_o,          // card byte index in buffer
	output logic                   fifo_side_en_o,     // acquisition or replay enable
	output logic                   notify_evt_o        // block announce event pulse
);
	typedef struct packed {
		drb_phase_t       phase;
		logic             dir_h2c;
		logic [CNT_W-1:0] buf_len;
		logic [CNT_W-1:0] user_length;
		logic [CNT_W-1:0] user_pos;
		logic [CNT_W-1:0] card_length;
		logic [CNT_W-1:0] card_pos;
		logic [CNT_W-1:0] pend;
		logic [31:0]      notify;
		logic [31:0]      rel_hi;
		logic             ovr;
		logic             unr;
		logic             blk_rdy;
		logic             evt;
		logic             ack;
		logic [31:0]      rdata;
	} drb_state_t;

	drb_state_t       s_q;
	drb_state_t       s_d;
	logic [9:0]       fill_pm;
	logic [IDX_W-1:0] idx;
	logic             wr;
	logic             running;
	logic [CNT_W-1:0] rel;
	logic [CNT_W-1:0] mv;
	logic [CNT_W-1:0] notify_w;

	// advance a ring position, wrapping at the buffer length
	function automatic logic [CNT_W-1:0] wrap_add(input logic [CNT_W-1:0] pos,
		input logic [CNT_W-1:0] amt, input logic [CNT_W-1:0] len);
		logic [CNT_W:0] sum;
		sum = {1'b0, pos} + {1'b0, amt};
		if (sum >= {1'b0, len}) begin
			sum = sum - {1'b0, len};
		end
		return sum[CNT_W-1:0];
	endfunction

	// clamp a requested amount to what is available
	function automatic logic [CNT_W-1:0] clamp(input logic [CNT_W-1:0] amt,
		input logic [CNT_W-1:0] lim);
		return (amt > lim) ? lim : amt;
	endfunction

	drb_fill_permille u_fill (
		.ref_clk_i  (ref_clk_i),
		.reset_i    (reset_i),
		.level_i    (fifo_level_i),
		.permille_o (fill_pm)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	assign idx     = avs_address_i[ADDR_W-1:2];
	assign running = (s_q.phase == PH_RUN);
	// only full-word writes land; partial writes would tear the 64-bit counters
	assign wr      = avs_write_i && s_q.ack && (avs_byteenable_i == 4'hf);
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_q.ack;
	assign notify_w = CNT_W'(s_q.notify);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d     = s_q;
		s_d.evt = 1'b0;
		s_d.ack = (avs_read_i || avs_write_i) && !s_q.ack;

		// read data is built in the wait cycle and held through the answer
		if (avs_read_i && !s_q.ack) begin
			unique case (idx)
				REG_USER_LENGTH:              s_d.rdata = s_q.user_length[31:0];
				REG_USER_LENGTH + REG_HI_OFS: s_d.rdata = s_q.user_length[63:32];
				REG_USER_POS:              s_d.rdata = s_q.user_pos[31:0];
				REG_USER_POS + REG_HI_OFS: s_d.rdata = s_q.user_pos[63:32];
				REG_CTRL:                  s_d.rdata = {30'h0, s_q.dir_h2c, 1'b0};
				REG_STATUS:                s_d.rdata = {27'h0, s_q.dir_h2c, s_q.blk_rdy,
					s_q.unr, s_q.ovr, running};
				REG_BUF_LEN:               s_d.rdata = s_q.buf_len[31:0];
				REG_BUF_LEN + REG_HI_OFS:  s_d.rdata = s_q.buf_len[63:32];
				REG_NOTIFY:                s_d.rdata = s_q.notify;
				REG_FILL:                  s_d.rdata = {22'h0, fill_pm};
				default:                   s_d.rdata = 32'h0;
			endcase
		end

		// release from the host, taken from the user side
		rel = '0;
		if (wr && idx == REG_CARD_REL && running) begin
			rel = clamp({s_q.rel_hi, avs_writedata_i}, s_q.user_length);
		end
		if (wr && idx == REG_CARD_REL + REG_HI_OFS) begin
			s_d.rel_hi = avs_writedata_i;
		end

		// bytes moved by the dma, taken from the card side
		mv = '0;
		if (running && dma_done_i) begin
			mv = clamp(CNT_W'(dma_bytes_i), s_q.card_length);
		end

		// both directions share the arithmetic; only the meaning of the bytes differs
		s_d.user_length = s_q.user_length - rel;
		s_d.card_length = s_q.card_length - mv + rel;
		s_d.pend     = s_q.pend + mv;
		s_d.user_pos = wrap_add(s_q.user_pos, rel, s_q.buf_len);
		s_d.card_pos = wrap_add(s_q.card_pos, mv, s_q.buf_len);

		// moved bytes are withheld until a whole notify block exists; one block per cycle
		if (notify_w != '0 && s_d.pend >= notify_w) begin
			s_d.user_length = s_d.user_length + notify_w;
			s_d.pend     = s_d.pend - notify_w;
			s_d.blk_rdy  = 1'b1;
			s_d.evt      = (s_d.pend < notify_w);
		end else if (wr && idx == REG_STATUS && avs_writedata_i[STAT_BLK_BIT]) begin
			s_d.blk_rdy = 1'b0;
		end

		// fifo errors
		if (running && !s_q.dir_h2c && fifo_overrun_i) begin
			s_d.ovr = 1'b1;
		end
		if (running && s_q.dir_h2c && fifo_underrun_i) begin
			s_d.unr   = 1'b1;
			s_d.phase = PH_HALT;
		end
		// after an overrun the run lasts until the fifo has drained
		if (running && s_q.ovr && fifo_empty_i) begin
			s_d.phase = PH_HALT;
		end

		// configuration and commands
		if (wr && s_q.phase != PH_RUN) begin
			unique case (idx)
				REG_BUF_LEN:              s_d.buf_len[31:0]  = avs_writedata_i;
				REG_BUF_LEN + REG_HI_OFS: s_d.buf_len[63:32] = avs_writedata_i;
				REG_NOTIFY:               s_d.notify         = avs_writedata_i;
				default:                  s_d.rdata          = s_d.rdata;
			endcase
		end
		if (wr && idx == REG_CTRL) begin
			if (avs_writedata_i[CTRL_STOP_BIT]) begin
				s_d.phase = running ? PH_HALT : s_q.phase;
			end else if (avs_writedata_i[CTRL_START_BIT]) begin
				s_d.phase    = PH_RUN;
				s_d.dir_h2c  = avs_writedata_i[CTRL_DIR_BIT];
				s_d.user_length = '0;
				s_d.card_length = s_q.buf_len;
				s_d.user_pos = '0;
				s_d.card_pos = '0;
				s_d.pend     = '0;
				s_d.ovr      = 1'b0;
				s_d.unr      = 1'b0;
				s_d.blk_rdy  = 1'b0;
				s_d.evt      = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s_q         <= '0;
			s_q.phase   <= PH_IDLE;
			s_q.buf_len <= BUF_LEN_RST;
			s_q.notify  <= NOTIFY_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// dma runs unattended while card space remains and the run lasts; after an overrun it halts at the end of the drain
	assign dma_move_o     = running && (s_q.card_length != '0)
		&& !(s_q.ovr && fifo_empty_i);
	// the fifo side is independent of the host buffer filling up
	assign fifo_side_en_o = running && !s_q.ovr && !s_q.unr;
	assign dma_pos_o      = s_q.card_pos;
	assign notify_evt_o   = s_q.evt;
	assign avs_readdata_o = s_q.rdata;
endmodule // drb_ring_ctrl
`default_nettype wire

// file: verification/drb_ring_ctrl_chk.sv
// Purpose: port assertions for drb_ring_ctrl. Assumes: one clock, sync reset
// Notes: bound to the top module below its endmodule
`timescale 1ns/1ps
`default_nettype none
module drb_ring_chk
	import drb_pkg::*;
(
	input wire logic              ref_clk_i,         // clock
	input wire logic              reset_i,           // reset
	input wire logic [ADDR_W-1:0] avs_address_i,     // addr
	input wire logic              avs_read_i,        // rd
	input wire logic              avs_write_i,       // wr
	input wire logic [31:0]       avs_writedata_i,   // wdata
	input wire logic [3:0]        avs_byteenable_i,  // lanes
	input wire logic [31:0]       avs_readdata_o,    // rdata
	input wire logic              avs_waitrequest_o, // stall
	input wire logic              dma_done_i,        // chunk
	input wire logic [31:0]       dma_bytes_i,       // size
	input wire logic [4:0]        fifo_level_i,      // level
	input wire logic              fifo_empty_i,      // empty
	input wire logic              fifo_overrun_i,    // ovr
	input wire logic              fifo_underrun_i,   // unr
	input wire logic              dma_move_o,        // move
	input wire logic [CNT_W-1:0]  dma_pos_o,         // pos
	input wire logic              fifo_side_en_o,    // enable
	input wire logic              notify_evt_o       // event
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_fault;
		fifo_side_en_o && fifo_overrun_i && fifo_underrun_i;
	endsequence
	a_one_wait: assert property (s_req |=> !avs_waitrequest_o)
		else $error("request not answered after one wait");
	a_idle_free: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("stall without request");
	a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved without a read");
	a_evt_single: assert property (notify_evt_o |=> !notify_evt_o)
		else $error("event longer than one cycle");
	a_fault_stop: assert property (s_fault |=> !fifo_side_en_o)
		else $error("fifo side kept running after fault");
	a_drain_end: assert property (!fifo_side_en_o && fifo_empty_i && !avs_write_i
		|-> ##1 !dma_move_o)
		else $error("dma moving with empty fifo after stop");
	a_rst_idle: assert property ($fell(reset_i) |-> !dma_move_o && dma_pos_o == '0)
		else $error("not idle after reset");
	a_pos_cause: assert property ($changed(dma_pos_o) |-> $past(dma_done_i) || $past(avs_write_i))
		else $error("card position moved without cause");
endmodule // drb_ring_chk
bind drb_ring_ctrl drb_ring_chk drb_ring_chk_inst (.ref_clk_i, .reset_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
	.avs_waitrequest_o, .dma_done_i, .dma_bytes_i, .fifo_level_i, .fifo_empty_i,
	.fifo_overrun_i, .fifo_underrun_i, .dma_move_o, .dma_pos_o, .fifo_side_en_o, .notify_evt_o);
`default_nettype wire

// file: verification/drb_dma_model.sv
// Purpose: data mover on the far side. Assumes: one chunk per request
// Notes: count is only meaningful with done; it toggles elsewhere
`timescale 1ns/1ps
`default_nettype none
module drb_dma_model (
	input  wire logic        ref_clk_i, // clock
	input  wire logic        reset_i,   // reset
	input  wire logic        go_i,      // chunk wanted
	input  wire logic [31:0] len_i,     // chunk size
	input  wire logic        move_i,    // device lets data move
	output logic             done_o,    // chunk done pulse
	output logic      [31:0] bytes_o    // size with done
);
	always_ff @(posedge ref_clk_i) begin
		done_o  <= !reset_i && go_i && move_i && !done_o;
		bytes_o <= reset_i ? 32'h0 : (go_i && move_i && !done_o) ? len_i : ~bytes_o;
	end
endmodule // drb_dma_model
`default_nettype wire

// file: verification/drb_ring_ctrl_tb.sv
// Purpose: self-checking bench for drb_ring_ctrl. Assumes: one wait state per access
// Notes: expected lengths come from bytes moved and released, not from the device
`timescale 1ns/1ps
`default_nettype none
module drb_ring_ctrl_tb;
	localparam int BLEN = 32'h400;
	localparam int NTF = 32'h100;
	logic ref_clk_i, reset_i, avs_read_i, avs_write_i, dma_done_i, fifo_empty_i;
	logic fifo_overrun_i, fifo_underrun_i, dma_move_o, fifo_side_en_o, notify_evt_o;
	logic avs_waitrequest_o, dma_go;
	logic [3:0] avs_byteenable_i;
	logic [11:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, dma_bytes_i, dma_len, rdat, seed;
	logic [4:0] fifo_level_i;
	logic [63:0] dma_pos_o;
	int error_cnt, n_tests, m, r, evt_cnt;
	drb_ring_ctrl drb_ring_ctrl_inst (.ref_clk_i, .reset_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .dma_done_i, .dma_bytes_i, .fifo_level_i, .fifo_empty_i,
		.fifo_overrun_i, .fifo_underrun_i, .dma_move_o, .dma_pos_o, .fifo_side_en_o,
		.notify_evt_o);
	drb_dma_model drb_dma_model_inst (.ref_clk_i, .reset_i, .go_i(dma_go), .len_i(dma_len),
		.move_i(dma_move_o), .done_o(dma_done_i), .bytes_o(dma_bytes_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// sole driver of the event count, cleared by reset
	always @(posedge ref_clk_i)
		if (reset_i === 1'b1)
			evt_cnt <= 0;
		else if (notify_evt_o === 1'b1)
			evt_cnt <= evt_cnt + 1;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// only whole notify blocks are announced
	function automatic logic [31:0] exp_len();
		return 32'((m / NTF) * NTF - r);
	endfunction
	task automatic close_out;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int k;
		@(posedge ref_clk_i);
		avs_address_i   <= a;
		avs_writedata_i <= wd;
		avs_write_i     <= w;
		avs_read_i      <= !w;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 50);
		rdat = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
		if (k >= 50) begin
			chk(0, 1, "bus timeout");
			close_out();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdat, e, "read");
	endtask
	// host never releases more than it was given
	task automatic rel(input int n);
		bus(1'b1, 12'h728, 32'h0);
		bus(1'b1, 12'h328, 32'(n));
		r += n;
	endtask
	task automatic chunk(input int n);
		int k;
		dma_go  <= 1'b1;
		dma_len <= 32'(n);
		k = 0;
		do begin
			@(negedge ref_clk_i);
			k++;
		end while (dma_done_i !== 1'b1 && k < 50);
		@(posedge ref_clk_i);
		dma_go <= 1'b0;
		m += n;
		repeat (6) @(posedge ref_clk_i);
		if (k >= 50) begin
			chk(0, 1, "dma timeout");
			close_out();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{avs_read_i, avs_write_i, dma_go, fifo_overrun_i, fifo_underrun_i} = '0;
		{avs_address_i, avs_writedata_i, dma_len, fifo_level_i} = '0;
		{error_cnt, n_tests, m, r} = '0;
		avs_byteenable_i = 4'hf;
		fifo_empty_i = 1'b1;
		reset_i = 1'b1;
		seed = 32'h3c6aa6b0;
		repeat (8) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd(12'h348, 32'h0001_0000);
		// a partial-lane write is answered but must not land
		avs_byteenable_i <= 4'h1;
		bus(1'b1, 12'h34c, 32'h40);
		avs_byteenable_i <= 4'hf;
		rd(12'h34c, 32'h0000_1000);
		rd(12'h3fc, 32'h0);
		bus(1'b1, 12'h348, BLEN);
		bus(1'b1, 12'h34c, NTF);
		bus(1'b1, 12'h340, 32'h1);
		rd(12'h320, 32'h0);
		rd(12'h324, 32'h0);
		chunk(32'h80);
		rd(12'h320, exp_len());
		chk(evt_cnt, 0, "early event");
		chunk(32'h90);
		rd(12'h320, exp_len());
		chk(evt_cnt, 1, "event count");
		rel(32'h100);
		rd(12'h324, 32'h100);
		rd(12'h320, exp_len());
		chunk(BLEN - m + r);
		rd(12'h320, exp_len());
		chk(evt_cnt, 2, "one event per batch");
		chk(dma_pos_o[31:0], 32'(m % BLEN), "card position");
		chk(dma_move_o, 0, "moving without card space");
		chk(fifo_side_en_o, 1, "fifo side stopped on full buffer");
		rel(32'h300);
		rd(12'h324, 32'(r % BLEN));
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			chunk(seed[5:0] + 1);
			rd(12'h320, exp_len());
		end
		for (int i = 0; i <= 16; i++) begin
			fifo_level_i <= 5'(i);
			rd(12'h350, 32'(i * 1000 / 16));
		end
		// both faults at once: only the one of this direction may count
		fifo_empty_i    <= 1'b0;
		fifo_overrun_i  <= 1'b1;
		fifo_underrun_i <= 1'b1;
		@(posedge ref_clk_i);
		fifo_overrun_i  <= 1'b0;
		fifo_underrun_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(fifo_side_en_o, 0, "fifo side enabled");
		chk(dma_move_o, 1, "drain stopped");
		rd(12'h344, 32'h0000_000b);
		fifo_empty_i <= 1'b1;
		repeat (2) @(negedge ref_clk_i);
		chk(dma_move_o, 0, "moving when empty");
		bus(1'b1, 12'h340, 32'h4);
		bus(1'b1, 12'h340, 32'h3);
		{m, r} = '0;
		rd(12'h320, 32'h0);
		chunk(NTF);
		rd(12'h320, exp_len());
		fifo_underrun_i <= 1'b1;
		@(posedge ref_clk_i);
		fifo_underrun_i <= 1'b0;
		rd(12'h344, 32'h0000_001c);
		chk(dma_move_o, 0, "moving after underrun");
		close_out();
	end
endmodule // drb_ring_ctrl_tb
`default_nettype wire
